/* File: shared/tmlm_cfg.svh */
// Constants of the transport mode lane mapper: register offsets, field
// positions, reset values and mapping widths.
// Assumes a 32-bit APB register bus with byte addresses.
`ifndef TMLM_CFG_SVH
`define TMLM_CFG_SVH
`define TMLM_ADDR_MODE       8'h00
`define TMLM_ADDR_KM1        8'h04
`define TMLM_ADDR_DID        8'h08
`define TMLM_ADDR_THR        8'h0C
`define TMLM_ADDR_PARAM      8'h10
`define TMLM_ADDR_IDS        8'h14
`define TMLM_ADDR_FCNT       8'h18
`define TMLM_MODE_RST        7'h3F
`define TMLM_KM1_RST         8'h1F
`define TMLM_DID_RST         8'h00
`define TMLM_THR_FIRST_RST   12'hC00
`define TMLM_THR_SECOND_RST  12'hF00
`define TMLM_THR_SECOND_LSB  16
`define TMLM_PAR_L_LSB       0
`define TMLM_PAR_M_LSB       4
`define TMLM_PAR_F_LSB       8
`define TMLM_PAR_S_LSB       12
`define TMLM_PAR_D_LSB       16
`define TMLM_PAR_ENC_BIT     24
`define TMLM_PAR_DUAL_BIT    25
`define TMLM_PAR_BYP_BIT     26
`define TMLM_IDS_B_LSB       8
`define TMLM_K_MAX           9'h100
`define TMLM_K64_NUM         9'h100
`define TMLM_TAIL_BITS       7'h04
`define TMLM_LANE_BITS       7'h40
`define TMLM_SAMP_W          12
`define TMLM_DDC_W           15
`endif

/* File: shared/tmlm_pkg.sv */
// Types of the transport mode lane mapper.
// Assumes tmlm_cfg.svh for all numeric constants.
package tmlm_pkg;

  // Legal link mode selector codes.
  typedef enum logic [6:0] {
    MODE_BYP12_S8L = 7'h1E,
    MODE_D16_DUAL_A = 7'h3B,
    MODE_D16_DUAL_B = 7'h3C,
    MODE_D16_SGL_A = 7'h3D,
    MODE_D16_SGL_B = 7'h3E,
    MODE_D16_SGL_C = 7'h3F,
    MODE_D16_SGL_D = 7'h40,
    MODE_D16_SGL_E = 7'h41,
    MODE_D32_DUAL_A = 7'h42,
    MODE_D32_DUAL_B = 7'h43,
    MODE_D32_DUAL_C = 7'h44,
    MODE_D32_SGL_A = 7'h45,
    MODE_D32_SGL_B = 7'h46,
    MODE_D32_SGL_C = 7'h47
  } tmlm_mode_code_type;

  // How incoming words are spread over the lanes of a link.
  typedef enum logic [1:0] {
    FILL_BYPASS = 2'b00,
    FILL_WIDE   = 2'b01,
    FILL_SPLIT  = 2'b10,
    FILL_SINGLE = 2'b11
  } tmlm_fill_type;

  // Transport parameters fixed by one mode.
  typedef struct packed {
    logic       valid;
    logic       enc64;
    logic       dual;
    logic       bypass;
    logic [5:0] dec;
    logic [3:0] lanes;
    logic [3:0] conv;
    logic [3:0] octets;
    logic [3:0] spf;
    logic [1:0] ext;
    logic [8:0] kmin;
    logic [8:0] kstep;
  } tmlm_mode_type;

endpackage

/* File: tb/tmlm_rx_model.sv */
// Receiver model: rebuilds the link A word stream from the used lanes.
// Assumes framer outputs synchronous to pclk.
`timescale 1ns/1ps
module tmlm_rx_model (
  // Clock.
  input wire logic         pclk,
  // Frame side.
  input wire logic         frame_valid,
  input wire logic [511:0] link_a_lane_data,
  input wire logic [7:0]   link_a_lane_en
);
  logic [15:0] words [$];
  // Used lanes are read lane 0 first, so streams come back in time order.
  always @(posedge pclk) begin
    if (frame_valid === 1'b1) begin
      for (int l = 0; l < 8; l++) begin
        if (link_a_lane_en[l] === 1'b1)
          words.push_back(link_a_lane_data[64*l+48 +: 16]);
      end
    end
  end
endmodule

/* File: tb/transport_mode_lane_mapper_test.sv */
// Self-checking bench for the lane mapper: APB setup and a framed burst.
// Assumes ce held high and the channel B I input tied off.
`timescale 1ns/1ps
module transport_mode_lane_mapper_test;
  logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic          pwrite = 1'b0, in_valid = 1'b0, err;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0, rd;
  logic [14:0]   ai = 15'h0, aq = 15'h0;
  logic [11:0]   lva = 12'h0, lvb = 12'h0;
  logic [14:0]   bq = 15'h0;
  logic [95:0]   smp = 96'h0;
  wire logic [31:0]  prdata;
  wire logic         pready, pslverr, fv, mfs;
  wire logic [511:0] lad, lbd;
  wire logic [7:0]   lea, leb, dida, didb;
  wire logic [8:0]   kact;
  int            fails = 0, checks_done = 0;
  tmlm_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_ready(), .adc_samples(smp), .ddc_a_i(ai),
    .ddc_a_q(aq), .ddc_b_i(15'h0), .ddc_b_q(bq), .chan_a_level(lva),
    .chan_b_level(lvb), .frame_valid(fv), .multiframe_start(mfs),
    .link_a_lane_data(lad), .link_b_lane_data(lbd), .link_a_lane_en(lea),
    .link_b_lane_en(leb), .link_a_did(dida), .link_b_did(didb),
    .k_active(kact));
  tmlm_rx_model rx (.pclk(pclk), .frame_valid(fv),
    .link_a_lane_data(lad), .link_a_lane_en(lea));
  // Free-running 50 MHz clock.
  always #10 pclk = ~pclk;
  // Compare and count.
  task automatic chk(input string n, input logic [63:0] s, e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Report and stop.
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One APB transfer from the next rising edge; it returns mid-cycle so
  // that registered outputs updated by the write have settled.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
  endtask
  // Reset values, identifiers and lane enables of the reset mode.
  task automatic t_reset();
    apb(1'b0, 8'h00, 32'h0);
    chk("mode", rd[6:0], 7'h3F);
    apb(1'b0, 8'h04, 32'h0);
    chk("km1", rd[7:0], 8'h1F);
    chk("k", kact, 9'd32);
    apb(1'b1, 8'h08, 32'h2A);
    chk("did_a", dida, 8'h2A);
    chk("did_b", didb, 8'h2B);
    chk("lanes63", lea, 8'h0F);
  endtask
  // Refused codes and the fixed K of a 64b/66b mode.
  task automatic t_modes();
    apb(1'b1, 8'h00, 32'h05);
    chk("bad_mode", err, 1'b1);
    apb(1'b1, 8'h00, 32'd68);
    chk("k68", kact, 9'd64);
    chk("lanes68", lea, 8'h01);
    chk("lanes68b", leb, 8'h01);
    apb(1'b1, 8'h04, 32'h0F);
    chk("km1_64b", err, 1'b1);
    apb(1'b1, 8'h00, 32'd62);
    apb(1'b1, 8'h04, 32'h14);
    chk("km1_step", err, 1'b1);
    apb(1'b1, 8'h04, 32'h0F);
    chk("k62", kact, 9'd16);
  endtask
  // Two sets of mode 62 form one frame; words are checked via the model.
  task automatic t_frame();
    int n;
    @(posedge pclk);
    in_valid <= 1'b1;
    ai <= 15'h1234;
    aq <= 15'h0ABC;
    lva <= 12'hF80;
    @(posedge pclk);
    ai <= 15'h0555;
    lva <= 12'h000;
    @(posedge pclk);
    in_valid <= 1'b0;
    for (n = 0; n < 20 && fv !== 1'b1; n++) @(negedge pclk);
    if (n >= 20) begin
      fails++;
      wrap_up();
    end
    chk("tail", lad[47:0], 48'h0);
    chk("mf_start", mfs, 1'b1);
    chk("q0", lbd[63:48], {15'h0ABC, 1'b1});
    @(negedge pclk);
    chk("word0", rx.words[0], {15'h1234, 1'b1});
    chk("word1", rx.words[1], {15'h0555, 1'b0});
  endtask
  // Dual mode 67 splits I and Q over two lanes; bypass mode 30 spreads
  // even samples over link A and odd samples over link B.
  task automatic t_dual_byp();
    apb(1'b1, 8'h00, 32'd67);
    @(posedge pclk);
    in_valid <= 1'b1;
    aq <= 15'h2468;
    bq <= 15'h1357;
    lvb <= 12'hFFF;
    @(posedge pclk);
    in_valid <= 1'b0;
    @(negedge pclk);
    chk("dual_a_q", lad[127:112], {15'h2468, 1'b0});
    chk("dual_b_q", lbd[127:112], {15'h1357, 1'b1});
    apb(1'b1, 8'h00, 32'd30);
    chk("k30", kact, 9'd32);
    for (int n = 0; n < 5; n++) begin
      @(posedge pclk);
      in_valid <= 1'b1;
      smp <= {72'h0, 12'hB00 + 12'(n), 12'hA00 + 12'(n)};
    end
    @(posedge pclk);
    in_valid <= 1'b0;
    @(negedge pclk);
    chk("byp_a0", lad[63:0], {48'hA00A01A02A03, 12'hA04, 4'h0});
    chk("byp_b0", lbd[63:0], {48'hB00B01B02B03, 12'hB04, 4'h0});
    chk("byp_tail", {lad[3:0], lbd[3:0]}, 8'h00);
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_modes();
    t_frame();
    t_dual_byp();
    wrap_up();
  end
endmodule

/* File: verilog/tmlm_top.sv */
// Transport layer mode table and sample-to-octet lane mapper, APB slave.
// Assumes sample inputs synchronous to pclk; one input set per in_valid.
//
// Overview of operation
// R1: Only listed mode selector values are accepted; each fixes all parameters.
// R2: In 8b/10b modes K comes from the k-minus-one field within mode range.
// R3: In 64b/66b modes K is fixed at 256*E/F and not programmable.
// R4: Sixteen lanes form two links of eight; every mode uses both links.
// R5: Lowest L lanes of each link are used, higher lanes powered down.
// R6: Link A reports the programmed device id, link B that plus one.
// R7: Flagged bypass modes set M equal to L for time-ordered lanes.
// R8: The receiver interleaves the M streams of each link.
// R9: Without decimation 12-bit offset-binary samples are packed into octets.
// R10: Down-converter words are 15 data bits plus one overrange bit.
// R11: Every tail bit of every frame is zero.
// R12: Samples go out most significant bit first.
// R13: Single-channel flags set when sample exceeds first or second threshold.
// R14: Dual-channel modes carry separate first and second flags per channel.
// R15: Modes 59 and 60: decimate-by-16 dual-channel 64b/66b.
// R16: Modes 61 to 63: decimate-by-16 single-channel 8b/10b, K 16:8:256.
// R17: Modes 64 and 65: decimate-by-16 single-channel 64b/66b, K 128.
// R18: Modes 66 and 67: decimate-by-32 dual-channel 8b/10b.
// R19: Mode 68: decimate-by-32 dual-channel 64b/66b, one lane, K 64.
// R20: Modes 69 and 70: decimate-by-32 single-channel 8b/10b.
// R21: Mode 71: decimate-by-32 single-channel 64b/66b, one lane, K 128.
// R22: Eight-lane bypass puts even samples on link A, odd on link B.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`include "tmlm_cfg.svh"
`timescale 1ns/1ps

module tmlm_top #(
  parameter int ADDR_W = 8
) (
  // Clock, reset and clock enable.
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  // APB slave.
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Sample input stream.
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire logic [95:0]         adc_samples,
  input  wire logic [14:0]         ddc_a_i,
  input  wire logic [14:0]         ddc_a_q,
  input  wire logic [14:0]         ddc_b_i,
  input  wire logic [14:0]         ddc_b_q,
  input  wire logic [11:0]         chan_a_level,
  input  wire logic [11:0]         chan_b_level,
  // Frame output towards the link layer.
  output logic                     frame_valid,
  output logic                     multiframe_start,
  output logic      [511:0]        link_a_lane_data,
  output logic      [511:0]        link_b_lane_data,
  output logic      [7:0]          link_a_lane_en,
  output logic      [7:0]          link_b_lane_en,
  output logic      [7:0]          link_a_did,
  output logic      [7:0]          link_b_did,
  output logic      [8:0]          k_active
);

  // Build one table entry.
  function automatic tmlm_pkg::tmlm_mode_type mk(
    input logic e64, input logic du, input logic by, input logic [5:0] d,
    input logic [3:0] l, input logic [3:0] m, input logic [3:0] f,
    input logic [3:0] s, input logic [8:0] kmn, input logic [8:0] kst);
    tmlm_pkg::tmlm_mode_type r;
    r = '{1'b1, e64, du, by, d, l, m, f, s, 2'h1, kmn, kst};
    return r;
  endfunction

  // Mode table; any code not listed comes back invalid.
  function automatic tmlm_pkg::tmlm_mode_type lookup(input logic [6:0] c);
    tmlm_pkg::tmlm_mode_type r;
    r = '0;
    unique case (c)
      tmlm_pkg::MODE_BYP12_S8L:                                          // R7
        r = mk(1'b1, 1'b0, 1'b1, 6'h01, 4'h4, 4'h4, 4'h8, 4'h5, 9'h0, 9'h1);
      tmlm_pkg::MODE_D16_DUAL_A:                                         // R15
        r = mk(1'b1, 1'b1, 1'b0, 6'h10, 4'h1, 4'h2, 4'h4, 4'h1, 9'h0, 9'h1);
      tmlm_pkg::MODE_D16_DUAL_B:                                         // R15
        r = mk(1'b1, 1'b1, 1'b0, 6'h10, 4'h2, 4'h2, 4'h2, 4'h1, 9'h0, 9'h1);
      tmlm_pkg::MODE_D16_SGL_A:                                          // R16
        r = mk(1'b0, 1'b0, 1'b0, 6'h10, 4'h1, 4'h1, 4'h2, 4'h1, 9'h10, 9'h8);
      tmlm_pkg::MODE_D16_SGL_B:                                          // R16
        r = mk(1'b0, 1'b0, 1'b0, 6'h10, 4'h2, 4'h1, 4'h2, 4'h2, 9'h10, 9'h8);
      tmlm_pkg::MODE_D16_SGL_C:                                          // R16
        r = mk(1'b0, 1'b0, 1'b0, 6'h10, 4'h4, 4'h1, 4'h2, 4'h4, 9'h10, 9'h8);
      tmlm_pkg::MODE_D16_SGL_D:                                          // R17
        r = mk(1'b1, 1'b0, 1'b0, 6'h10, 4'h1, 4'h1, 4'h2, 4'h1, 9'h0, 9'h1);
      tmlm_pkg::MODE_D16_SGL_E:                                          // R17
        r = mk(1'b1, 1'b0, 1'b0, 6'h10, 4'h2, 4'h1, 4'h2, 4'h2, 9'h0, 9'h1);
      tmlm_pkg::MODE_D32_DUAL_A:                                         // R18
        r = mk(1'b0, 1'b1, 1'b0, 6'h20, 4'h1, 4'h2, 4'h4, 4'h1, 9'h8, 9'h4);
      tmlm_pkg::MODE_D32_DUAL_B:                                         // R18
        r = mk(1'b0, 1'b1, 1'b0, 6'h20, 4'h2, 4'h2, 4'h2, 4'h1, 9'h10, 9'h8);
      tmlm_pkg::MODE_D32_DUAL_C:                                         // R19
        r = mk(1'b1, 1'b1, 1'b0, 6'h20, 4'h1, 4'h2, 4'h4, 4'h1, 9'h0, 9'h1);
      tmlm_pkg::MODE_D32_SGL_A:                                          // R20
        r = mk(1'b0, 1'b0, 1'b0, 6'h20, 4'h1, 4'h1, 4'h2, 4'h1, 9'h10, 9'h8);
      tmlm_pkg::MODE_D32_SGL_B:                                          // R20
        r = mk(1'b0, 1'b0, 1'b0, 6'h20, 4'h2, 4'h1, 4'h2, 4'h2, 9'h10, 9'h8);
      tmlm_pkg::MODE_D32_SGL_C:                                          // R21
        r = mk(1'b1, 1'b0, 1'b0, 6'h20, 4'h1, 4'h1, 4'h2, 4'h1, 9'h0, 9'h1);
      default: r = '0;
    endcase
    return r;
  endfunction

  // Fixed K of a 64b/66b mode; F is always a power of two here.
  function automatic logic [8:0] k_fixed(input tmlm_pkg::tmlm_mode_type p);
    logic [8:0] num;
    num = `TMLM_K64_NUM * {7'h0, p.ext};
    unique case (p.octets)
      4'h2: return num >> 1;
      4'h4: return num >> 2;
      4'h8: return num >> 3;
      default: return num;
    endcase
  endfunction

  // Registers.
  logic [6:0]  link_mode_select;
  logic [7:0]  k_minus_one_field;
  logic [7:0]  device_id;
  logic [11:0] overrange_threshold_first;
  logic [11:0] overrange_threshold_second;
  logic [31:0] frame_count;
  logic [2:0]  fill_cnt;
  logic [8:0]  mf_idx;

  // Current mode and derived values.
  tmlm_pkg::tmlm_mode_type cur;
  tmlm_pkg::tmlm_mode_type req;
  tmlm_pkg::tmlm_fill_type fill;
  logic [8:0] k_eff;
  logic [8:0] k_cur;
  logic [8:0] k_req;
  assign cur = lookup(link_mode_select);                                 // R1
  assign req = lookup(pwdata[6:0]);
  assign k_cur = {1'b0, k_minus_one_field} + 9'h1;
  assign k_req = {1'b0, pwdata[7:0]} + 9'h1;
  assign k_eff = cur.enc64 ? k_fixed(cur) : k_cur;                       // R3
  assign fill = cur.bypass ? tmlm_pkg::FILL_BYPASS :
                !cur.dual ? tmlm_pkg::FILL_SINGLE :
                (cur.octets == 4'h4) ? tmlm_pkg::FILL_WIDE :
                tmlm_pkg::FILL_SPLIT;

  // APB decode; the bus never waits while the block is enabled.
  logic sel_mode, sel_km1, sel_did, sel_thr, sel_par, sel_ids, sel_fcnt;
  logic mapped, acc, wr_acc, mode_ok, km1_ok, mode_wr, km1_wr, refused;
  logic km1_fix;
  assign sel_mode = paddr == `TMLM_ADDR_MODE;
  assign sel_km1  = paddr == `TMLM_ADDR_KM1;
  assign sel_did  = paddr == `TMLM_ADDR_DID;
  assign sel_thr  = paddr == `TMLM_ADDR_THR;
  assign sel_par  = paddr == `TMLM_ADDR_PARAM;
  assign sel_ids  = paddr == `TMLM_ADDR_IDS;
  assign sel_fcnt = paddr == `TMLM_ADDR_FCNT;
  assign mapped = sel_mode | sel_km1 | sel_did | sel_thr | sel_par |
                  sel_ids | sel_fcnt;
  assign acc = ce & psel & penable;
  assign wr_acc = acc & pwrite;
  assign mode_ok = req.valid & (pwdata[31:7] == 25'h0);                  // R1
  // K must lie on the mode's grid; 64b/66b modes refuse any write.
  assign km1_ok = !cur.enc64 & (pwdata[31:8] == 24'h0) &                 // R2
                  (k_req >= cur.kmin) & (k_req <= `TMLM_K_MAX) &
                  ((k_req & (cur.kstep - 9'h1)) == 9'h0);                // R3
  assign mode_wr = wr_acc & sel_mode & mode_ok;
  assign km1_wr = wr_acc & sel_km1 & km1_ok;
  assign refused = (pwrite & sel_mode & !mode_ok) |
                   (pwrite & sel_km1 & !km1_ok);
  // A new 8b/10b mode whose grid excludes the old K restarts at its least K.
  assign km1_fix = !req.enc64 & ((k_cur < req.kmin) |
                   ((k_cur & (req.kstep - 9'h1)) != 9'h0));
  assign pready = ce;
  assign pslverr = psel & penable & (!mapped | refused);

  // Read data is captured in the setup cycle so it stands for the access.
  logic [31:0] rd_mux;
  assign rd_mux =
    sel_mode ? {25'h0, link_mode_select} :
    sel_km1  ? {23'h0, k_eff - 9'h1} :
    sel_did  ? {24'h0, device_id} :
    sel_thr  ? ({20'h0, overrange_threshold_first} |
                ({20'h0, overrange_threshold_second} <<
                 `TMLM_THR_SECOND_LSB)) :
    sel_par  ? (({28'h0, cur.lanes} << `TMLM_PAR_L_LSB) |
                ({28'h0, cur.conv} << `TMLM_PAR_M_LSB) |
                ({28'h0, cur.octets} << `TMLM_PAR_F_LSB) |
                ({28'h0, cur.spf} << `TMLM_PAR_S_LSB) |
                ({26'h0, cur.dec} << `TMLM_PAR_D_LSB) |
                ({31'h0, cur.enc64} << `TMLM_PAR_ENC_BIT) |
                ({31'h0, cur.dual} << `TMLM_PAR_DUAL_BIT) |
                ({31'h0, cur.bypass} << `TMLM_PAR_BYP_BIT)) :
    sel_ids  ? ({24'h0, link_a_did} |
                ({24'h0, link_b_did} << `TMLM_IDS_B_LSB)) :
    sel_fcnt ? frame_count : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (ce & psel & !penable) begin
      prdata <= rd_mux;
    end
  end

  // Configuration registers; refused writes leave them untouched.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_mode_select <= `TMLM_MODE_RST;
      k_minus_one_field <= `TMLM_KM1_RST;
      device_id <= `TMLM_DID_RST;
      overrange_threshold_first <= `TMLM_THR_FIRST_RST;
      overrange_threshold_second <= `TMLM_THR_SECOND_RST;
    end else begin
      if (mode_wr) begin
        link_mode_select <= pwdata[6:0];                                 // R1
      end
      if (km1_wr) begin
        k_minus_one_field <= pwdata[7:0];                                // R2
      end else if (mode_wr & km1_fix) begin
        k_minus_one_field <= 8'(req.kmin - 9'h1);
      end
      if (wr_acc & sel_did) begin
        device_id <= pwdata[7:0];
      end
      if (wr_acc & sel_thr) begin
        overrange_threshold_first <= pwdata[11:0];
        overrange_threshold_second <= pwdata[27:16];
      end
    end
  end

  // Overrange flags and 16-bit words: 15 data bits, flag in the LSB.
  logic overrange_flag_first, overrange_flag_second;
  logic chan_a_overrange_first, chan_a_overrange_second;
  logic chan_b_overrange_first, chan_b_overrange_second;
  logic [15:0] word_a0, word_a1, word_b0, word_b1;
  assign overrange_flag_first = chan_a_level > overrange_threshold_first;
  assign overrange_flag_second = chan_a_level > overrange_threshold_second;
  assign chan_a_overrange_first = overrange_flag_first;                  // R14
  assign chan_a_overrange_second = overrange_flag_second;                // R14
  assign chan_b_overrange_first = chan_b_level > overrange_threshold_first;
  assign chan_b_overrange_second = chan_b_level > overrange_threshold_second;
  // Single channel sends I on link A and Q on link B.
  assign word_a0 = cur.dual ? {ddc_a_i, chan_a_overrange_first}          // R10
                            : {ddc_a_i, overrange_flag_first};           // R13
  assign word_a1 = {ddc_a_q, chan_a_overrange_second};
  assign word_b0 = cur.dual ? {ddc_b_i, chan_b_overrange_first}          // R14
                            : {ddc_a_q, overrange_flag_second};          // R13
  assign word_b1 = {ddc_b_q, chan_b_overrange_second};

  // Frame assembly control.
  logic in_take, frame_done;
  logic [2:0] fill_lim;
  logic [6:0] shift_w, used_bits, out_sh;
  assign in_ready = ce;
  assign in_take = ce & in_valid;
  assign fill_lim = (fill == tmlm_pkg::FILL_BYPASS) ? 3'(cur.spf - 4'h1) :
                    (fill == tmlm_pkg::FILL_SINGLE) ? 3'(cur.lanes - 4'h1) :
                    3'h0;
  assign frame_done = in_take & (fill_cnt == fill_lim);
  assign shift_w = (fill == tmlm_pkg::FILL_BYPASS) ? 7'(`TMLM_SAMP_W) :
                   (fill == tmlm_pkg::FILL_WIDE) ? 7'h20 : 7'h10;
  // Bypass frames end in tail bits; the final shift leaves them zero.
  assign used_bits = {cur.octets[3:0], 3'b000} -
                     (cur.bypass ? `TMLM_TAIL_BITS : 7'h00);             // R11
  assign out_sh = `TMLM_LANE_BITS - used_bits;

  // Per-lane shifters: a lane shifts in new bits at its LSB end, so the
  // first sample ends up in the top octet and goes out first.
  logic [63:0] lane_sr [0:15];
  logic [63:0] lane_q [0:15];
  for (genvar g = 0; g < 16; g++) begin : g_lane
    localparam int LN = g % 8;
    localparam int LK = g / 8;
    logic [15:0] w0, w1;
    logic [11:0] byp;
    logic [31:0] din;
    logic        ld;
    logic [63:0] shifted, framed;
    assign w0 = (LK == 1) ? word_b0 : word_a0;
    assign w1 = (LK == 1) ? word_b1 : word_a1;
    if (LN < 4) begin : g_byp
      assign byp = adc_samples[(2 * LN + LK) * `TMLM_SAMP_W +: 12];      // R22
    end else begin : g_nobyp
      assign byp = 12'h000;
    end
    assign din = (fill == tmlm_pkg::FILL_BYPASS) ? {20'h0, byp} :       // R9
                 (fill == tmlm_pkg::FILL_WIDE) ? {w0, w1} :
                 (fill == tmlm_pkg::FILL_SPLIT) ?
                   {16'h0, (LN == 0) ? w0 : w1} : {16'h0, w0};
    // Only the lowest L lanes of each link ever load.
    assign ld = in_take & ((fill == tmlm_pkg::FILL_SINGLE) ?
                (3'(LN) == fill_cnt) : ({1'b0, 3'(LN)} < cur.lanes));    // R5
    assign shifted = (lane_sr[g] << shift_w) | {32'h0, din};             // R12
    // A lane that is idle on the closing set frames its stored word, not din.
    assign framed = (ld ? shifted : lane_sr[g]) << out_sh;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lane_sr[g] <= 64'h0;
      end else if (ld) begin
        lane_sr[g] <= shifted;
      end
    end
    // Lanes above L stay at zero on every frame.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lane_q[g] <= 64'h0;
      end else if (frame_done) begin
        lane_q[g] <= ({1'b0, 3'(LN)} < cur.lanes) ? framed : 64'h0;      // R5
      end
    end
    if (LK == 0) begin : g_a
      assign link_a_lane_data[LN * 64 +: 64] = lane_q[g];                // R4
    end else begin : g_b
      assign link_b_lane_data[LN * 64 +: 64] = lane_q[g];                // R4
    end
  end

  // Fill position, multiframe position and frame counter; a mode change
  // restarts the fill and multiframe positions (frame_count keeps counting) so no frame mixes two layouts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_cnt <= 3'h0;
      mf_idx <= 9'h0;
      frame_count <= 32'h0;
    end else if (mode_wr) begin
      fill_cnt <= 3'h0;
      mf_idx <= 9'h0;
    end else if (in_take) begin
      fill_cnt <= frame_done ? 3'h0 : fill_cnt + 3'h1;
      if (frame_done) begin
        mf_idx <= (mf_idx >= k_eff - 9'h1) ? 9'h0 : mf_idx + 9'h1;
        frame_count <= frame_count + 32'h1;
      end
    end
  end

  // Frame strobes and link-facing parameters.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_valid <= 1'b0;
      multiframe_start <= 1'b0;
      link_a_lane_en <= 8'h00;
      link_b_lane_en <= 8'h00;
      link_a_did <= 8'h00;
      link_b_did <= 8'h00;
      k_active <= 9'h0;
    end else if (ce) begin
      frame_valid <= frame_done & !mode_wr;
      multiframe_start <= frame_done & !mode_wr & (mf_idx == 9'h0);
      link_a_lane_en <= 8'((9'h1 << cur.lanes) - 9'h1);                 // R5
      link_b_lane_en <= 8'((9'h1 << cur.lanes) - 9'h1);                 // R4
      link_a_did <= device_id;                                           // R6
      link_b_did <= device_id + 8'h01;                                   // R6
      k_active <= k_eff;                                                 // R2
    end
  end

  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  mode_legal_a: assert property (cur.valid)                              // R1
    else $error("mode register holds an unlisted code");
  mode_refuse_a: assert property (wr_acc & sel_mode & !mode_ok           // R1
    |=> $stable(link_mode_select))
    else $error("illegal mode code was stored");
  km1_locked_a: assert property (wr_acc & sel_km1 & cur.enc64            // R3
    |-> pslverr ##1 $stable(k_minus_one_field))
    else $error("K write accepted in a 64b66b mode");
  k_fixed_a: assert property (cur.enc64 & cur.valid                      // R3
    |-> ({4'h0, k_eff} * {9'h0, cur.octets}) == 13'h100)
    else $error("fixed K is not 256 over F");
  k_grid_a: assert property (!cur.enc64                                  // R2
    |-> k_eff >= cur.kmin && ((k_eff & (cur.kstep - 9'h1)) == 9'h0))
    else $error("K off the mode grid");
  lane_off_a: assert property (frame_valid                               // R5
    |-> (link_a_lane_en[cur.lanes[2:0]] == 1'b0 || cur.lanes == 4'h8)
        && link_a_lane_data[511:448] == 64'h0)
    else $error("unused lane carries data");
  did_pair_a: assert property (ce ##1 1'b1                               // R6
    |-> link_b_did == link_a_did + 8'h01)
    else $error("link B id is not link A id plus one");
  tail_zero_a: assert property (frame_valid & cur.bypass                 // R11
    |-> link_a_lane_data[3:0] == 4'h0 && link_b_lane_data[3:0] == 4'h0)
    else $error("tail bits not zero");
  byp_order_a: assert property (frame_done & !mode_wr & cur.bypass       // R22
    |=> link_a_lane_data[15:4] == $past(adc_samples[11:0])
        && link_b_lane_data[15:4] == $past(adc_samples[23:12]))
    else $error("bypass sample landed on the wrong lane");
  dual_flag_a: assert property (frame_done & !mode_wr                    // R14
    & (fill == tmlm_pkg::FILL_SPLIT)
    |=> link_a_lane_data[48] == $past(chan_a_overrange_first)
        && link_b_lane_data[112] == $past(chan_b_overrange_second))
    else $error("dual overrange flag misplaced");

  bypass_frame_c: cover property (frame_valid & cur.bypass);
  single4_frame_c: cover property (frame_valid & (cur.lanes == 4'h4)
    & !cur.dual & !cur.bypass);
  mf_start_c: cover property (multiframe_start ##1 !multiframe_start);
  refused_wr_c: cover property (pslverr & pwrite & sel_km1);

endmodule
